// *** alie_regs.svh ***
/*
 Constants of the arithmetic/logic execution block: reset values, flag
 positions and cycle counts. Assumes inclusion by bare name.
*/
`ifndef ALIE_REGS_SVH
`define ALIE_REGS_SVH
`define ALIE_WREG_RST      8'h00
`define ALIE_PC_RST        11'h000
`define ALIE_ZERO_BYTE     8'h00
`define ALIE_FLAG_CARRY    0
`define ALIE_FLAG_HALF     1
`define ALIE_FLAG_ZERO     2
`define ALIE_FLAG_WRAP     3
`define ALIE_CALL_CYCLES   2'h2
`define ALIE_PC_STEP       11'h001
`endif

// *** alie_pkg.sv ***
/*
 Types of the arithmetic/logic execution block.
 Assumes alie_regs.svh holds the numeric constants.
*/
package alie_pkg;
    typedef enum logic [3:0] {
        ALIE_OP_NONE,
        ALIE_OP_SUM_CARRY_TO_WREG,
        ALIE_OP_SUM_WITH_CARRY_INTO_MEMORY,
        ALIE_OP_SUM_TO_WREG,
        ALIE_OP_SUM_IMM_TO_WREG,
        ALIE_OP_SUM_INTO_MEMORY,
        ALIE_OP_AND_TO_WREG,
        ALIE_OP_AND_IMM_TO_WREG,
        ALIE_OP_BITWISE_CONJUNCTION_INTO_MEMORY,
        ALIE_OP_SUBROUTINE_JUMP,
        ALIE_OP_ZERO_MEMORY_BYTE
    } alie_op_t;

    typedef enum {
        ALIE_ST_IDLE,
        ALIE_ST_CALL2
    } alie_state_t;

    // Issued instruction
    typedef struct packed {
        alie_op_t    op;
        logic [7:0]  mem_data;
        logic [7:0]  imm;
        logic [10:0] target;
    } alie_instr_t;

    // Status flags
    typedef struct packed {
        logic signed_wrap_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } alie_flags_t;

    // Data memory write-back
    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } alie_mem_wr_t;

    // Stack push
    typedef struct packed {
        logic        push;
        logic [10:0] addr;
    } alie_push_t;

    // Whole module state
    typedef struct packed {
        logic [1:0]   state;
        logic [7:0]   working_register;
        alie_flags_t  flags;
        logic [10:0]  pc;
        logic [10:0]  call_target;
        alie_mem_wr_t mem_wr;
        alie_push_t   push;
        logic         done;
    } alie_state_vec_t;
endpackage : alie_pkg

// *** alie_exec.sv ***
/*
 Execution unit for sums, conjunctions, subroutine jump and byte clear.
 Assumes the fetch logic presents one instruction with issue_in high,
 with the addressed data byte already read, and waits for ready_out.
*/
// Contract
// - Sum with carry to working register stores wreg+byte+carry in wreg and sets wrap, zero, half and carry flags.
// - Sum with carry into memory writes wreg+byte+carry to the byte and sets wrap, zero, half and carry flags.
// - Plain sum stores wreg+byte in wreg and sets wrap, zero, half and carry flags.
// - Sum immediate stores wreg+imm in wreg and sets wrap, zero, half and carry flags.
// - Sum into memory writes wreg+byte to the byte and sets wrap, zero, half and carry flags.
// - Conjunction with memory stores wreg&byte in wreg and changes only the zero flag.
// - Conjunction with immediate stores wreg&imm in wreg and changes only the zero flag.
// - Conjunction into memory writes wreg&byte back to the byte and leaves wreg unchanged.
// - Subroutine jump pushes pc+1 on the stack then loads the target into pc.
// - Subroutine jump takes two cycles and changes no flags.
// - Zero memory byte writes 00 to the byte and changes no flags.
`include "alie_regs.svh"
module alie_exec (
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 clk_en_in,
    // Instruction issue
    input  wire logic                 issue_in,
    input  wire alie_pkg::alie_instr_t instr_in,
    output logic                      ready_out,
    output logic                      done_out,
    // Architectural state
    output logic [7:0]                working_register_out,
    output alie_pkg::alie_flags_t     flags_out,
    output logic [10:0]               pc_out,
    // Memory and stack
    output alie_pkg::alie_mem_wr_t    mem_wr_out,
    output alie_pkg::alie_push_t      push_out
);
    alie_pkg::alie_state_vec_t st_r;
    alie_pkg::alie_state_vec_t st_nxt;

    // Sum with flag generation
    function automatic logic [11:0] alie_sum(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        logic       wrap;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        wrap = (a[7] == b[7]) && (full[7] != a[7]);
        // Result, wrap, zero, half, carry
        alie_sum = {full[7:0], wrap, (full[7:0] == 8'h00), lo[4], full[8]};
    endfunction : alie_sum

    logic [11:0] sum_res;
    logic [7:0]  and_res;
    logic [7:0]  opnd;
    logic        cin;

    always_comb begin
        st_nxt = st_r;
        st_nxt.mem_wr.we = 1'b0;
        st_nxt.push.push = 1'b0;
        st_nxt.done = 1'b0;
        opnd = (instr_in.op == alie_pkg::ALIE_OP_SUM_IMM_TO_WREG ||
                instr_in.op == alie_pkg::ALIE_OP_AND_IMM_TO_WREG) ? instr_in.imm : instr_in.mem_data;
        cin = (instr_in.op == alie_pkg::ALIE_OP_SUM_CARRY_TO_WREG ||
               instr_in.op == alie_pkg::ALIE_OP_SUM_WITH_CARRY_INTO_MEMORY) ? st_r.flags.carry : 1'b0;
        sum_res = alie_sum(st_r.working_register, opnd, cin);
        and_res = st_r.working_register & opnd;
        case (alie_pkg::alie_state_t'(st_r.state))
            alie_pkg::ALIE_ST_IDLE: begin
                if (issue_in) begin
                    case (instr_in.op)
                        alie_pkg::ALIE_OP_SUM_CARRY_TO_WREG,
                        alie_pkg::ALIE_OP_SUM_TO_WREG,
                        alie_pkg::ALIE_OP_SUM_IMM_TO_WREG: begin
                            st_nxt.working_register = sum_res[11:4];
                            st_nxt.flags = sum_res[3:0];
                            st_nxt.pc = st_r.pc + `ALIE_PC_STEP;
                            st_nxt.done = 1'b1;
                        end
                        alie_pkg::ALIE_OP_SUM_WITH_CARRY_INTO_MEMORY,
                        alie_pkg::ALIE_OP_SUM_INTO_MEMORY: begin
                            st_nxt.mem_wr.we = 1'b1;
                            st_nxt.mem_wr.data = sum_res[11:4];
                            st_nxt.flags = sum_res[3:0];
                            st_nxt.pc = st_r.pc + `ALIE_PC_STEP;
                            st_nxt.done = 1'b1;
                        end
                        alie_pkg::ALIE_OP_AND_TO_WREG,
                        alie_pkg::ALIE_OP_AND_IMM_TO_WREG: begin
                            st_nxt.working_register = and_res;
                            st_nxt.flags.zero = (and_res == `ALIE_ZERO_BYTE);
                            st_nxt.pc = st_r.pc + `ALIE_PC_STEP;
                            st_nxt.done = 1'b1;
                        end
                        alie_pkg::ALIE_OP_BITWISE_CONJUNCTION_INTO_MEMORY: begin
                            st_nxt.mem_wr.we = 1'b1;
                            st_nxt.mem_wr.data = and_res;
                            st_nxt.flags.zero = (and_res == `ALIE_ZERO_BYTE);
                            st_nxt.pc = st_r.pc + `ALIE_PC_STEP;
                            st_nxt.done = 1'b1;
                        end
                        alie_pkg::ALIE_OP_SUBROUTINE_JUMP: begin
                            st_nxt.push.push = 1'b1;
                            st_nxt.push.addr = st_r.pc + `ALIE_PC_STEP;
                            st_nxt.call_target = instr_in.target;
                            st_nxt.state = 2'(alie_pkg::ALIE_ST_CALL2);
                        end
                        alie_pkg::ALIE_OP_ZERO_MEMORY_BYTE: begin
                            st_nxt.mem_wr.we = 1'b1;
                            st_nxt.mem_wr.data = `ALIE_ZERO_BYTE;
                            st_nxt.pc = st_r.pc + `ALIE_PC_STEP;
                            st_nxt.done = 1'b1;
                        end
                        default: begin
                            st_nxt.pc = st_r.pc + `ALIE_PC_STEP;
                            st_nxt.done = 1'b1;
                        end
                    endcase
                end
            end
            alie_pkg::ALIE_ST_CALL2: begin
                st_nxt.pc = st_r.call_target;
                st_nxt.done = 1'b1;
                st_nxt.state = 2'(alie_pkg::ALIE_ST_IDLE);
            end
            default: begin
                st_nxt.state = 2'(alie_pkg::ALIE_ST_IDLE);
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= '0;
            st_r.working_register <= `ALIE_WREG_RST;
            st_r.pc <= `ALIE_PC_RST;
        end else if (clk_en_in) begin
            st_r <= st_nxt;
        end
    end

    assign ready_out            = (st_r.state == 2'(alie_pkg::ALIE_ST_IDLE));
    assign done_out             = st_r.done;
    assign working_register_out = st_r.working_register;
    assign flags_out            = st_r.flags;
    assign pc_out               = st_r.pc;
    assign mem_wr_out           = st_r.mem_wr;
    assign push_out             = st_r.push;
endmodule : alie_exec

// *** alie_exec_monitor.sv ***
/* Checker for the execution unit ports.
   Assumes one clock and an active-low reset. */
module alie_exec_monitor (
    // Inputs seen
    input wire logic                  mclk_in,
    input wire logic                  reset_n_in,
    input wire logic                  clk_en_in,
    input wire logic                  issue_in,
    input wire alie_pkg::alie_instr_t instr_in,
    input wire logic                  ready_out,
    input wire logic                  done_out,
    input wire logic [7:0]            working_register_out,
    input wire alie_pkg::alie_flags_t flags_out,
    input wire logic [10:0]           pc_out,
    input wire alie_pkg::alie_mem_wr_t mem_wr_out,
    input wire alie_pkg::alie_push_t  push_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic go = issue_in & ready_out & clk_en_in;
    wire logic [3:0] op = instr_in.op;
    wire logic t_call = go && op == alie_pkg::ALIE_OP_SUBROUTINE_JUMP;
    a_call_push: assert property (t_call |=> push_out.push && push_out.addr == $past(pc_out) + 11'h001)
        else $error("return address push wrong");
    a_call_target: assert property (t_call ##1 clk_en_in |=> done_out && pc_out == $past(instr_in.target, 2))
        else $error("jump target not loaded in second cycle");
    a_call_two: assert property (t_call |=> !ready_out && !done_out && $stable(flags_out))
        else $error("jump not two cycles or flags moved");
    a_clear_byte: assert property (go && op == alie_pkg::ALIE_OP_ZERO_MEMORY_BYTE
        |=> mem_wr_out.we && mem_wr_out.data == 8'h00 && $stable(flags_out)) else $error("byte clear wrong");
    a_sum_memory: assert property (go && (op == alie_pkg::ALIE_OP_SUM_INTO_MEMORY
        || op == alie_pkg::ALIE_OP_SUM_WITH_CARRY_INTO_MEMORY) |=> mem_wr_out.we && $stable(working_register_out)
        && {flags_out.carry, mem_wr_out.data} == $past({1'b0, working_register_out} + instr_in.mem_data
        + (flags_out.carry && op == alie_pkg::ALIE_OP_SUM_WITH_CARRY_INTO_MEMORY)))
        else $error("sum into memory wrong");
    a_and_wreg: assert property (go && op == alie_pkg::ALIE_OP_AND_TO_WREG |=> working_register_out
        == $past(working_register_out & instr_in.mem_data) && $stable(flags_out.carry)
        && $stable(flags_out.half_carry_flag) && $stable(flags_out.signed_wrap_flag))
        else $error("conjunction with memory wrong");
    a_and_mem: assert property (go && op == alie_pkg::ALIE_OP_BITWISE_CONJUNCTION_INTO_MEMORY
        |=> mem_wr_out.data == $past(working_register_out & instr_in.mem_data) && $stable(working_register_out)
        && flags_out.zero == (mem_wr_out.data == 8'h00)) else $error("conjunction into memory wrong");
    a_sum_carry: assert property (go && op == alie_pkg::ALIE_OP_SUM_CARRY_TO_WREG |=> {flags_out.carry,
        working_register_out} == $past({1'b0, working_register_out} + instr_in.mem_data + flags_out.carry))
        else $error("sum with carry wrong");
    a_sum_plain: assert property (go && op == alie_pkg::ALIE_OP_SUM_TO_WREG |=> {flags_out.carry,
        working_register_out} == $past({1'b0, working_register_out} + instr_in.mem_data)) else $error("sum wrong");
    a_sum_imm: assert property (go && op == alie_pkg::ALIE_OP_SUM_IMM_TO_WREG |=> {flags_out.carry,
        working_register_out} == $past({1'b0, working_register_out} + instr_in.imm)) else $error("sum imm wrong");
    a_and_imm: assert property (go && op == alie_pkg::ALIE_OP_AND_IMM_TO_WREG |=> working_register_out
        == $past(working_register_out & instr_in.imm) && $stable(flags_out.carry)) else $error("and imm wrong");
endmodule : alie_exec_monitor
bind alie_exec alie_exec_monitor u_mon (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .issue_in(issue_in), .instr_in(instr_in), .ready_out(ready_out), .done_out(done_out), .pc_out(pc_out),
    .working_register_out(working_register_out), .flags_out(flags_out), .mem_wr_out(mem_wr_out), .push_out(push_out));

// *** arith_logic_instr_exec_tb_top.sv ***
/* Directed testbench of the execution unit.
   Assumes the checker is bound to the design. */
module arith_logic_instr_exec_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_in, reset_n_in, clk_en_in, issue_in, ready_out, done_out;
    logic [7:0] working_register_out;
    logic [10:0] pc_out, pc_x;
    alie_pkg::alie_instr_t instr_in;
    alie_pkg::alie_flags_t flags_out;
    alie_pkg::alie_mem_wr_t mem_wr_out;
    alie_pkg::alie_push_t push_out;
    int error_cnt, checked;
    alie_exec DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .issue_in(issue_in),
        .instr_in(instr_in), .ready_out(ready_out), .done_out(done_out), .working_register_out(working_register_out),
        .flags_out(flags_out), .pc_out(pc_out), .mem_wr_out(mem_wr_out), .push_out(push_out));
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    task automatic chk(logic [31:0] s, logic [31:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic step(alie_pkg::alie_op_t op, logic [7:0] m, logic [7:0] wx, logic [3:0] fx, logic [8:0] mx);
        logic i;
        i = op inside {alie_pkg::ALIE_OP_SUM_IMM_TO_WREG, alie_pkg::ALIE_OP_AND_IMM_TO_WREG};
        issue_in = 1'b1;
        instr_in = '{op, i ? ~m : m, i ? m : ~m, 11'h7ff};
        @(posedge mclk_in);
        #1;
        pc_x = pc_x + 11'h001;
        chk({working_register_out, flags_out}, {wx, fx});
        chk({mem_wr_out, done_out, pc_out}, {mx, 1'b1, pc_x});
    endtask : step
    task automatic t_arith();
        step(alie_pkg::ALIE_OP_SUM_IMM_TO_WREG, 8'h7f, 8'h7f, 4'h0, 9'h000);
        step(alie_pkg::ALIE_OP_SUM_IMM_TO_WREG, 8'h01, 8'h80, 4'ha, 9'h000);
        step(alie_pkg::ALIE_OP_SUM_TO_WREG, 8'h80, 8'h00, 4'hd, 9'h000);
        step(alie_pkg::ALIE_OP_SUM_CARRY_TO_WREG, 8'h0f, 8'h10, 4'h2, 9'h000);
        step(alie_pkg::ALIE_OP_SUM_INTO_MEMORY, 8'hf0, 8'h10, 4'h5, 9'h100);
        step(alie_pkg::ALIE_OP_SUM_WITH_CARRY_INTO_MEMORY, 8'h05, 8'h10, 4'h0, 9'h116);
    endtask : t_arith
    task automatic t_logic();
        step(alie_pkg::ALIE_OP_SUM_IMM_TO_WREG, 8'hff, 8'h0f, 4'h1, 9'h016);
        step(alie_pkg::ALIE_OP_AND_TO_WREG, 8'h3c, 8'h0c, 4'h1, 9'h016);
        step(alie_pkg::ALIE_OP_AND_IMM_TO_WREG, 8'h30, 8'h00, 4'h5, 9'h016);
        step(alie_pkg::ALIE_OP_SUM_IMM_TO_WREG, 8'h81, 8'h81, 4'h0, 9'h016);
        step(alie_pkg::ALIE_OP_BITWISE_CONJUNCTION_INTO_MEMORY, 8'hc0, 8'h81, 4'h0, 9'h180);
        step(alie_pkg::ALIE_OP_ZERO_MEMORY_BYTE, 8'h5a, 8'h81, 4'h0, 9'h100);
        step(alie_pkg::ALIE_OP_BITWISE_CONJUNCTION_INTO_MEMORY, 8'h7e, 8'h81, 4'h4, 9'h100);
        step(alie_pkg::ALIE_OP_ZERO_MEMORY_BYTE, 8'hff, 8'h81, 4'h4, 9'h100);
    endtask : t_logic
    task automatic t_call();
        instr_in = '{alie_pkg::ALIE_OP_SUBROUTINE_JUMP, 8'h00, 8'h00, 11'h5a3};
        @(posedge mclk_in);
        #1;
        chk({push_out, ready_out, done_out}, {1'b1, pc_x + 11'h001, 2'b00});
        instr_in = '{alie_pkg::ALIE_OP_SUM_IMM_TO_WREG, 8'h00, 8'h01, 11'h000};
        @(posedge mclk_in);
        #1;
        clk_en_in = 1'b0;
        chk({push_out.push, pc_out, ready_out, done_out}, {1'b0, 11'h5a3, 2'b11});
        chk({working_register_out, flags_out}, {8'h81, 4'h4});
        repeat (2) @(posedge mclk_in);
        #1;
        chk({pc_out, working_register_out}, {11'h5a3, 8'h81});
        clk_en_in = 1'b1;
        pc_x = 11'h5a3;
        step(alie_pkg::ALIE_OP_SUM_IMM_TO_WREG, 8'h01, 8'h82, 4'h0, 9'h000);
        step(alie_pkg::ALIE_OP_NONE, 8'h55, 8'h82, 4'h0, 9'h000);
        issue_in = 1'b0;
    endtask : t_call
    initial begin
        reset_n_in = 1'b0;
        clk_en_in = 1'b1;
        issue_in = 1'b0;
        instr_in = '0;
        pc_x = 11'h000;
        repeat (6) @(posedge mclk_in);
        #1;
        reset_n_in = 1'b1;
        chk({pc_out, working_register_out, flags_out, ready_out, done_out}, {23'h000000, 2'b10});
        t_arith();
        t_logic();
        t_call();
        give_verdict();
    end
    initial begin
        #2000;
        error_cnt++;
        give_verdict();
    end
endmodule : arith_logic_instr_exec_tb_top
